// ### core/bfp_ctl.sv
`timescale 1ns/1ps

// Overview of operation
// - one comparator scans cell and temperature checks, one the currents
// - cells are scanned one by one from cell 1 to selected top cell
// - overvoltage for its delay drops charge drive; recovers with hysteresis
// - after reset all cells start in overvoltage fault, cleared after delay
// - overvoltage cell balances until full charge or fault recovery
// - charge drive off enables state comparator; discharge current restores
// - undervoltage for its delay drops discharge drive; optional load check
// - during undervoltage, charge current restores discharge drive
// - undervoltage or override disables discharge overcurrent detectors
// - open wire held for delay drops both drives; recovers with hysteresis
// - open-wire delay starts at first low reading; all recoveries needed
// - first discharge overcurrent drops both drives; three recovery modes
// - second discharge overcurrent behaves the same way
// - short circuit drops both drives with the same recovery modes
// - charge overcurrent drops both drives; same modes, but load check needs load present
// - delay strap is read once after reset and picks paired delays
// - strap codes 6 and 7 take both delays from stored settings
// - recovery timer starts at trip; combined mode checks load at expiry
// - load pin pulldown only during load-recovered faults
// - load present or removed after pin is stable for the deglitch time
// - only the state comparator turns a drive on while a fault affecting it stands
module bfp_ctl #(
  parameter int NCELL    = bfp_pkg::NCELL,
  parameter int TICK_CYC = bfp_pkg::TICK_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic [2:0]       cell_count_select_i,
  input  wire logic [2:0]       overcurrent_delay_strap_i,
  input  wire logic             discharge_override_in_i,
  input  wire logic             cmp1_res_i,
  input  wire logic             cmp2_res_i,
  input  wire logic             chg_current_i,
  input  wire logic             dsg_current_i,
  input  wire logic             load_sense_pin_i,
  output logic                  load_sense_pin_o,
  output logic                  load_sense_pin_oe_o,
  output logic      [5:0]       cmp1_sel_o,
  output logic      [1:0]       cmp2_sel_o,
  output logic                  ocd_det_en_o,
  output logic                  state_cmp_en_o,
  output logic                  charge_fet_drive_o,
  output logic                  discharge_fet_drive_o,
  output logic      [NCELL-1:0] bal_o
);

  localparam int DW = bfp_pkg::DLY_W;
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int SW = 12;
  localparam int CW = $bits(bfp_pkg::bfp_cfg_s);

  // ****************************************
  // pin synchronisers and time base
  // ****************************************
  logic [SW-1:0] sy1_q;
  logic [SW-1:0] sy2_q;
  logic [TW-1:0] tick_cnt_q;
  logic          tick_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sy1_q <= '0;
      sy2_q <= '0;
    end
    else
    begin
      sy1_q <= {load_sense_pin_i, dsg_current_i, chg_current_i,
                discharge_override_in_i, cmp2_res_i, cmp1_res_i,
                overcurrent_delay_strap_i, cell_count_select_i};
      sy2_q <= sy1_q;
    end
  end

  wire [2:0] ccs_s     = sy2_q[2:0];
  wire [2:0] strap_s   = sy2_q[5:3];
  wire       cmp1_s    = sy2_q[6];
  wire       cmp2_s    = sy2_q[7];
  wire       ovr_s     = sy2_q[8];
  wire       chg_cur_s = sy2_q[9];
  wire       dsg_cur_s = sy2_q[10];
  wire       ld_s      = sy2_q[11];

  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick_cnt_q == TW'(TICK_CYC - 1))
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 1'b1;
    tick_q <= !rst_i && tick_cnt_q == TW'(TICK_CYC - 1);
  end

  // ****************************************
  // register file
  // ****************************************
  bfp_pkg::bfp_cfg_s cfg_q;
  logic              ack_q;
  logic [31:0]       dat_q;

  wire        req    = wb_cyc_i && wb_stb_i && !ack_q;
  wire [7:0]  adr_w  = {wb_adr_i[7:2], 2'b00};
  wire        wr_cfg = req && wb_we_i && adr_w == bfp_pkg::ADR_CTRL;
  wire [31:0] cfg_o  = 32'(cfg_q);
  wire [31:0] cfg_m;

  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_lane
      assign cfg_m[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8]
                                           : cfg_o[b*8 +: 8];
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_q <= bfp_pkg::CFG_RST;
    else if (wr_cfg)
      cfg_q <= cfg_m[CW-1:0];
  end

  // ****************************************
  // comparator 1 and 2 schedule
  // ****************************************
  logic [2:0] c1_idx_q;
  logic [2:0] c1_tst_q;
  logic [1:0] c2_sel_q;

  wire [2:0] cell_top = (ccs_s == 3'h0 || ccs_s > 3'(NCELL)) ?
                        3'(NCELL - 1) : ccs_s - 3'h1;
  wire       c1_temp  = c1_idx_q == bfp_pkg::TEMP_IDX;
  wire       c1_eor   = c1_temp ? c1_tst_q == bfp_pkg::T_LAST
                                : c1_tst_q == bfp_pkg::T_FC;
  wire [2:0] c1_nxt   = c1_idx_q >= cell_top ? bfp_pkg::TEMP_IDX
                                             : c1_idx_q + 3'h1;

  function automatic logic hit(input logic [2:0] idx, input logic [2:0] t);
    return tick_q && c1_idx_q == idx && c1_tst_q == t;
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      c1_idx_q <= '0;
      c1_tst_q <= '0;
      c2_sel_q <= '0;
    end
    else if (tick_q)
    begin
      c1_idx_q <= !c1_eor ? c1_idx_q : c1_temp ? 3'h0 : c1_nxt;
      c1_tst_q <= c1_eor ? 3'h0 : c1_tst_q + 3'h1;
      c2_sel_q <= c2_sel_q + 2'h1;
    end
  end

  assign cmp1_sel_o = {c1_idx_q, c1_tst_q};
  assign cmp2_sel_o = c2_sel_q;

  // ****************************************
  // cell and temperature faults
  // ****************************************
  logic [NCELL-1:0] ov_flt;
  logic [NCELL-1:0] uv_flt;
  logic [NCELL-1:0] ow_flt;
  logic [NCELL-1:0] fc_q;
  logic [NCELL-1:0] bal_q;
  logic [3:0]       tflt;

  wire [DW-1:0] ov_dly = bfp_pkg::ms2tk(bfp_pkg::OV_DLY_MS[cfg_q.ov_dly]);
  wire [DW-1:0] uv_dly = bfp_pkg::ms2tk(bfp_pkg::UV_DLY_MS[cfg_q.uv_dly]);
  wire [DW-1:0] ow_dly = bfp_pkg::ms2tk(bfp_pkg::OW_DLY_MS);
  wire [DW-1:0] t_dly  = bfp_pkg::ms2tk(bfp_pkg::TEMP_DLY_MS);

  genvar c;
  generate
    for (c = 0; c < NCELL; c++)
    begin : g_cell
      // unscanned cells are cleared so they cannot hold a drive off
      wire off = 3'(c) > cell_top;
      bfp_flt #(.INIT(1'b1), .W(DW)) u_ov (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .tick_i     (tick_q),
        .smp_trip_i (hit(3'(c), bfp_pkg::T_OVT)),
        .smp_rec_i  (hit(3'(c), bfp_pkg::T_OVR)),
        .res_i      (cmp1_s),
        .dly_i      (ov_dly),
        .clr_i      (off),
        .flt_o      (ov_flt[c])
      );
      bfp_flt #(.INIT(1'b0), .W(DW)) u_uv (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .tick_i     (tick_q),
        .smp_trip_i (hit(3'(c), bfp_pkg::T_UVT)),
        .smp_rec_i  (hit(3'(c), bfp_pkg::T_UVR)),
        .res_i      (cmp1_s),
        .dly_i      (uv_dly),
        .clr_i      (off),
        .flt_o      (uv_flt[c])
      );
      bfp_flt #(.INIT(1'b0), .W(DW)) u_ow (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .tick_i     (tick_q),
        .smp_trip_i (hit(3'(c), bfp_pkg::T_OWT)),
        .smp_rec_i  (hit(3'(c), bfp_pkg::T_OWR)),
        .res_i      (cmp1_s),
        .dly_i      (ow_dly),
        .clr_i      (off),
        .flt_o      (ow_flt[c])
      );
      always_ff @(posedge clk_i)
      begin
        if (rst_i || !ov_flt[c])
          fc_q[c] <= 1'b0;
        else if (hit(3'(c), bfp_pkg::T_FC) && cmp1_s)
          fc_q[c] <= 1'b1;
        bal_q[c] <= !rst_i && ov_flt[c] && !fc_q[c];
      end
    end
  endgenerate

  genvar t;
  generate
    for (t = 0; t < 4; t++)
    begin : g_temp
      bfp_flt #(.INIT(1'b0), .W(DW)) u_t (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .tick_i     (tick_q),
        .smp_trip_i (hit(bfp_pkg::TEMP_IDX, 3'(2 * t))),
        .smp_rec_i  (hit(bfp_pkg::TEMP_IDX, 3'(2 * t + 1))),
        .res_i      (cmp1_s),
        .dly_i      (t_dly),
        .clr_i      (1'b0),
        .flt_o      (tflt[t])
      );
    end
  endgenerate

  wire hot_charge_fault  = tflt[0];
  wire cold_charge_fault = tflt[1];
  wire ov_any = |ov_flt;
  wire ow_any = |ow_flt;
  wire uv_v   = |uv_flt;

  // ****************************************
  // load sense
  // ****************************************
  logic          ld_last_q;
  logic          ld_pres_q;
  logic          ld_rem_q;
  logic [DW-1:0] ld_cnt_q;
  logic          uv_hold_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || ld_s != ld_last_q)
    begin
      ld_last_q <= !rst_i && ld_s;
      ld_cnt_q  <= '0;
      ld_pres_q <= 1'b0;
      ld_rem_q  <= 1'b0;
    end
    else if (tick_q && ld_cnt_q >= bfp_pkg::ms2tk(bfp_pkg::LD_DEG_MS))
    begin
      ld_pres_q <= ld_s;
      ld_rem_q  <= !ld_s;
    end
    else if (tick_q)
      ld_cnt_q <= ld_cnt_q + 1'b1;
  end

  // optional load removal keeps undervoltage standing after voltage recovers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      uv_hold_q <= 1'b0;
    else if (uv_v)
      uv_hold_q <= 1'b1;
    else if (!cfg_q.uv_load || ld_rem_q)
      uv_hold_q <= 1'b0;
  end

  wire uv_any = uv_v || uv_hold_q;

  // ****************************************
  // current faults and recovery timer
  // ****************************************
  logic [3:0]        cur_flt;
  logic [3:0]        cur_clr;
  logic [DW-1:0]     rec_cnt_q;
  bfp_pkg::bfp_cur_e cur_q;
  bfp_pkg::bfp_cur_e cur_d;
  logic              rec_go;
  logic [2:0]        strap_q;
  logic              strap_done_q;
  logic [DW-1:0]     cur_dly [4];

  wire ocd_off  = uv_any || ovr_s;
  wire cur_any  = |cur_flt;
  wire [1:0] rec_mode = cfg_q.rec_mode;
  wire use_nvm  = strap_q >= bfp_pkg::STRAP_NVM;
  wire load_ok  = cur_flt[bfp_pkg::CUR_OCC] ? ld_pres_q : ld_rem_q;
  wire [DW-1:0] rec_dly = bfp_pkg::ms2tk(bfp_pkg::REC_MS[cfg_q.rec_long]);
  wire rec_exp  = rec_cnt_q >= rec_dly;

  // the strap is read once; later changes on the pin are ignored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strap_q      <= '0;
      strap_done_q <= 1'b0;
    end
    else if (tick_q && !strap_done_q)
    begin
      strap_q      <= strap_s;
      strap_done_q <= 1'b1;
    end
  end

  assign cur_dly[0] = use_nvm ?
    bfp_pkg::ms2tk(bfp_pkg::NVM_A_MS[cfg_q.nvm_a]) :
    bfp_pkg::ms2tk(bfp_pkg::STRAP_A_MS[strap_q]);
  assign cur_dly[1] = use_nvm ?
    bfp_pkg::ms2tk(bfp_pkg::NVM_B_MS[cfg_q.nvm_b]) :
    bfp_pkg::ms2tk(bfp_pkg::STRAP_B_MS[strap_q]);
  assign cur_dly[2] = bfp_pkg::us2tk(bfp_pkg::SCD_DLY_US[cfg_q.scd_long]);
  assign cur_dly[3] = bfp_pkg::ms2tk(bfp_pkg::OCC_DLY_MS);

  genvar k;
  generate
    for (k = 0; k < 4; k++)
    begin : g_cur
      // k: 0 first, 1 second discharge overcurrent, 2 short, 3 charge
      assign cur_clr[k] = rec_go || (k < 3 && ocd_off && !cur_flt[k]);
      bfp_flt #(.INIT(1'b0), .W(DW)) u_c (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .tick_i     (tick_q),
        .smp_trip_i (tick_q && c2_sel_q == 2'(k) &&
                     (k == 3 || !ocd_off)),
        .smp_rec_i  (1'b0),
        .res_i      (cmp2_s),
        .dly_i      (cur_dly[k]),
        .clr_i      (cur_clr[k]),
        .flt_o      (cur_flt[k])
      );
    end
  endgenerate

  always_comb
  begin
    cur_d  = cur_q;
    rec_go = 1'b0;
    case (cur_q)
      bfp_pkg::CUR_OK:
        if (cur_any)
          cur_d = rec_mode == bfp_pkg::REC_LOAD ? bfp_pkg::CUR_WAIT_LOAD
                                                : bfp_pkg::CUR_TIMING;
      bfp_pkg::CUR_TIMING:
        if (rec_exp && (rec_mode == bfp_pkg::REC_TIMER || load_ok))
          rec_go = 1'b1;
      bfp_pkg::CUR_WAIT_LOAD:
        if (load_ok)
          rec_go = 1'b1;
      default:
        cur_d = bfp_pkg::CUR_OK;
    endcase
    if (rec_go)
      cur_d = bfp_pkg::CUR_OK;
  end

  always_ff @(posedge clk_i)
  begin
    cur_q <= rst_i ? bfp_pkg::CUR_OK : cur_d;
    if (rst_i || cur_q != bfp_pkg::CUR_TIMING || rec_exp)
      rec_cnt_q <= '0;
    else if (tick_q)
      rec_cnt_q <= rec_cnt_q + 1'b1;
  end

  // ****************************************
  // drivers and pins
  // ****************************************
  logic chg_q;
  logic dsg_q;
  logic stcmp_q;
  logic ocd_en_q;
  logic ld_oe_q;
  logic ld_o_q;

  // faults that the state comparator must never override
  wire hard    = ow_any || tflt[2] || tflt[3] || cur_any;
  wire chg_off = ov_any || hot_charge_fault || cold_charge_fault || hard;
  wire dsg_off = uv_any || ovr_s || hard;
  wire chg_d   = !chg_off || (dsg_cur_s && !hard);
  wire dsg_d   = !dsg_off || (chg_cur_s && uv_any && !hard && !ovr_s);
  wire ld_need = (uv_any && cfg_q.uv_load) ||
                 (cur_any && rec_mode != bfp_pkg::REC_TIMER);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      chg_q    <= 1'b0;
      dsg_q    <= 1'b0;
      stcmp_q  <= 1'b1;
      ocd_en_q <= 1'b1;
      ld_oe_q  <= 1'b0;
      ld_o_q   <= 1'b0;
    end
    else
    begin
      chg_q    <= chg_d;
      dsg_q    <= dsg_d;
      stcmp_q  <= chg_off || uv_any;
      ocd_en_q <= !ocd_off;
      ld_oe_q  <= ld_need;
      ld_o_q   <= 1'b0;
    end
  end

  assign charge_fet_drive_o    = chg_q;
  assign discharge_fet_drive_o = dsg_q;
  assign state_cmp_en_o        = stcmp_q;
  assign ocd_det_en_o          = ocd_en_q;
  assign load_sense_pin_oe_o   = ld_oe_q;
  assign load_sense_pin_o      = ld_o_q;
  assign bal_o                 = bal_q;

  // ****************************************
  // bus read
  // ****************************************
  wire [31:0] rd_stat = {12'h0, strap_q, cur_q, ld_rem_q, ld_pres_q,
                         dsg_q, chg_q, cur_flt, tflt, ow_any, uv_any, ov_any};
  wire [31:0] rd_cell = 32'(ov_flt) | (32'(uv_flt) << bfp_pkg::CELL_UV_POS) |
                        (32'(ow_flt) << bfp_pkg::CELL_OW_POS);
  wire [31:0] rd_w    = adr_w == bfp_pkg::ADR_CTRL ? cfg_o :
                        adr_w == bfp_pkg::ADR_STAT ? rd_stat :
                        adr_w == bfp_pkg::ADR_CELL ? rd_cell : 32'h0;

  always_ff @(posedge clk_i)
  begin
    ack_q <= !rst_i && req;
    dat_q <= (req && !wb_we_i) ? rd_w : 32'h0;
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_cmp2_rotates: assert property (
    tick_q |=> cmp2_sel_o == $past(cmp2_sel_o) + 2'h1)
    else $error("comparator 2 slot did not advance");
  a_scan_wraps: assert property (
    (tick_q && c1_temp && c1_tst_q == bfp_pkg::T_LAST) |=> cmp1_sel_o == 6'h0)
    else $error("cell scan did not restart at cell 1");
  a_ov_chg_off: assert property (
    (ov_any && !dsg_cur_s) [*2] |-> !charge_fet_drive_o)
    else $error("charge drive on during overvoltage");
  a_reset_ov_state: assert property (
    $past(rst_i) |-> (&ov_flt) && !charge_fet_drive_o)
    else $error("overvoltage not assumed after reset");
  a_bal_needs_ov: assert property (
    (bal_o & ~$past(ov_flt)) == '0)
    else $error("balancing without overvoltage");
  a_stcmp_restore: assert property (
    (chg_off && dsg_cur_s && !hard) |=> charge_fet_drive_o && state_cmp_en_o)
    else $error("state comparator did not restore charge");
  a_uv_dsg_off: assert property (
    (uv_any && !chg_cur_s) |=> !discharge_fet_drive_o)
    else $error("discharge drive on during undervoltage");
  a_ocd_disabled: assert property (
    (uv_any || ovr_s) |=> !ocd_det_en_o)
    else $error("overcurrent detectors left enabled");
  a_ow_both_off: assert property (
    ow_any |=> !charge_fet_drive_o && !discharge_fet_drive_o)
    else $error("drive on during open wire");
  a_cur_timer_rel: assert property (
    (cur_q == bfp_pkg::CUR_TIMING && rec_exp && rec_mode == bfp_pkg::REC_TIMER)
      |=> cur_q == bfp_pkg::CUR_OK && !cur_any)
    else $error("timer expiry did not release current fault");
  a_ld_pulldown_off: assert property (
    (!uv_any && !cur_any) |=> !load_sense_pin_oe_o)
    else $error("load pulldown on without fault");

  c_ov_recover: cover property (ov_any ##[1:20] !ov_any);
  c_wait_load: cover property (cur_q == bfp_pkg::CUR_WAIT_LOAD ##1 rec_go);
  c_stcmp_on: cover property (chg_off && charge_fet_drive_o);

endmodule

// ### core/bfp_pkg.sv
package bfp_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 10000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS  = 1000000 / TICK_NS;
  localparam int DLY_W         = 20;
  localparam int NCELL         = 5;

  localparam int OW_DLY_MS     = 4500;
  localparam int TEMP_DLY_MS   = 4500;
  localparam int OCC_DLY_MS    = 10;
  localparam int LD_DEG_MS     = 1;
  localparam int OV_DLY_MS [4] = '{500, 1000, 2000, 4500};
  localparam int UV_DLY_MS [4] = '{1000, 2000, 4500, 9000};
  localparam int REC_MS [2]    = '{250, 500};
  localparam int SCD_DLY_US [2] = '{400, 960};
  localparam int NVM_A_MS [8]  = '{10, 20, 45, 90, 180, 350, 700, 1420};
  localparam int NVM_B_MS [8]  = '{5, 10, 20, 45, 90, 180, 350, 700};
  localparam int STRAP_A_MS [6] = '{1420, 700, 350, 180, 90, 45};
  localparam int STRAP_B_MS [6] = '{700, 350, 180, 90, 45, 20};

  // ****************************************
  // register map and codes
  // ****************************************
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_STAT    = 8'h04;
  localparam logic [7:0] ADR_CELL    = 8'h08;
  localparam int         CELL_UV_POS = 8;
  localparam int         CELL_OW_POS = 16;

  localparam logic [2:0] T_OVT    = 3'h0;
  localparam logic [2:0] T_OVR    = 3'h1;
  localparam logic [2:0] T_UVT    = 3'h2;
  localparam logic [2:0] T_UVR    = 3'h3;
  localparam logic [2:0] T_OWT    = 3'h4;
  localparam logic [2:0] T_OWR    = 3'h5;
  localparam logic [2:0] T_FC     = 3'h6;
  localparam logic [2:0] T_LAST   = 3'h7;
  localparam logic [2:0] TEMP_IDX = 3'h7;

  localparam logic [1:0] REC_LOAD  = 2'h0;
  localparam logic [1:0] REC_TIMER = 2'h1;
  localparam logic [2:0] STRAP_NVM = 3'h6;
  localparam int         CUR_OCC   = 3;

  typedef struct packed {
    logic [2:0] nvm_b;
    logic [2:0] nvm_a;
    logic       scd_long;
    logic       rec_long;
    logic       uv_load;
    logic [1:0] rec_mode;
    logic [1:0] uv_dly;
    logic [1:0] ov_dly;
  } bfp_cfg_s;

  localparam bfp_cfg_s CFG_RST = '0;

  typedef enum logic [1:0] {CUR_OK, CUR_TIMING, CUR_WAIT_LOAD} bfp_cur_e;

  function automatic logic [DLY_W-1:0] ms2tk(input int ms);
    return DLY_W'(ms * TICKS_PER_MS);
  endfunction

  function automatic logic [DLY_W-1:0] us2tk(input int us);
    return DLY_W'(us * TICKS_PER_MS / 1000);
  endfunction

endpackage

// ### core/bfp_flt.sv
`timescale 1ns/1ps

module bfp_flt #(
  parameter bit INIT = 1'b0,
  parameter int W    = bfp_pkg::DLY_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         tick_i,
  input  wire logic         smp_trip_i,
  input  wire logic         smp_rec_i,
  input  wire logic         res_i,
  input  wire logic [W-1:0] dly_i,
  input  wire logic         clr_i,
  output logic              flt_o
);

  logic [W-1:0] cnt_q;
  logic         run_q;

  // a fault only looks at recovery samples, a clean state at trip samples
  wire smp  = flt_o ? smp_rec_i : smp_trip_i;
  wire done = run_q && (cnt_q >= dly_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr_i)
    begin
      flt_o <= rst_i ? INIT : 1'b0;
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else if (smp && !res_i)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else if (smp && done)
    begin
      flt_o <= !flt_o;
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else
    begin
      if (smp)
        run_q <= 1'b1;
      if (tick_i && run_q && !done)
        cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule

// ### bench/bfp_pack_model.sv
`timescale 1ns/1ps

// ****************************************
// pack model: cells, sense resistor, load
// ****************************************
module bfp_pack_model (
  input  wire logic [5:0] cmp1_sel_i,
  input  wire logic [1:0] cmp2_sel_i,
  input  wire logic       short_on_i,
  input  wire logic       load_on_i,
  input  wire logic       ld_oe_i,
  output logic            cmp1_res_o,
  output logic            cmp2_res_o,
  output logic            ld_pin_o
);
  // healthy cells and thermistor: trip checks false, recovery checks true
  // test 6 is a trip check on the temperature slot, so it must read false
  assign cmp1_res_o = ((cmp1_sel_i[5:3] != 3'h7) & (cmp1_sel_i[2:0] == 3'h6))
                      | cmp1_sel_i[0];
  // only the short-circuit slot ever reports a fault
  assign cmp2_res_o = short_on_i & (cmp2_sel_i == 2'h2);
  // load pulls high; no load and no pulldown leaves the pin floating high
  assign ld_pin_o   = load_on_i | ~ld_oe_i;
endmodule

// ### bench/battery_fault_protect_ctl_tb_top.sv
`timescale 1ns/1ps

module battery_fault_protect_ctl_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ovr = 1'b0, short_circuit_fault = 1'b0;
  logic load = 1'b1;
  logic dsg_cur = 1'b0;
  logic [3:0] sel = 4'hf;
  logic [3:0] msk = 4'hf;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, c1r, c2r, ldp, ld_o, ld_oe, ocd_en, st_en, charge_fet_drive, discharge_fet_drive;
  logic [5:0] s1;
  logic [1:0] s2;
  logic [4:0] bal;
  logic [2:0] last_idx = 3'h0;
  wire [2:0] nxt_idx = (last_idx == 3'h2) ? 3'h7 :
                       (last_idx == 3'h7) ? 3'h0 : last_idx + 3'h1;
  int error_cnt = 0;
  int n_tests = 0;
  int i;

  `define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end

  always #5 clk_i = ~clk_i;

  bfp_ctl #(.NCELL(5), .TICK_CYC(4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cell_count_select_i(3'h3),
    .overcurrent_delay_strap_i(bfp_pkg::STRAP_NVM),
    .discharge_override_in_i(ovr), .cmp1_res_i(c1r), .cmp2_res_i(c2r),
    .chg_current_i(1'b0), .dsg_current_i(dsg_cur), .load_sense_pin_i(ldp),
    .load_sense_pin_o(ld_o), .load_sense_pin_oe_o(ld_oe),
    .cmp1_sel_o(s1), .cmp2_sel_o(s2), .ocd_det_en_o(ocd_en),
    .state_cmp_en_o(st_en), .charge_fet_drive_o(charge_fet_drive),
    .discharge_fet_drive_o(discharge_fet_drive), .bal_o(bal));

  bfp_pack_model pack (
    .cmp1_sel_i(s1), .cmp2_sel_i(s2), .short_on_i(short_circuit_fault), .load_on_i(load),
    .ld_oe_i(ld_oe), .cmp1_res_o(c1r), .cmp2_res_o(c2r), .ld_pin_o(ldp));

  // ****************************************
  // bus access
  // ****************************************
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    sel <= msk;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task wait_oe(input logic v);
    for (i = 0; i < 20000 && ld_oe !== v; i++) @(posedge clk_i);
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // scan order with three cells selected: 1,2,3 then temperature
  always @(posedge clk_i)
    if (!rst_i && s1[5:3] !== last_idx)
    begin
      `CHK(s1[5:3], nxt_idx)
      last_idx <= s1[5:3];
    end

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(charge_fet_drive, 1'b0)
    `CHK(ld_oe, 1'b0)
    // discharge current overrides the reset overvoltage on the charge drive
    dsg_cur <= 1'b1;
    repeat (10) @(posedge clk_i);
    `CHK(charge_fet_drive, 1'b1)
    `CHK(st_en, 1'b1)
    `CHK(bal, 5'h07)
    dsg_cur <= 1'b0;
    repeat (10) @(posedge clk_i);
    `CHK(charge_fet_drive, 1'b0)
    wb(1'b0, bfp_pkg::ADR_STAT, 32'h0);
    `CHK(q[0], 1'b1)
    `CHK(q[19:17], bfp_pkg::STRAP_NVM)
    wb(1'b1, bfp_pkg::ADR_CTRL, 32'h0000_0080);
    wb(1'b0, bfp_pkg::ADR_CTRL, 32'h0);
    `CHK(q, 32'h0000_0080)
    // only lane 1 is written: short delay goes long, lane 0 keeps its value
    msk = 4'h2;
    wb(1'b1, bfp_pkg::ADR_CTRL, 32'h0000_0101);
    msk = 4'hf;
    wb(1'b0, bfp_pkg::ADR_CTRL, 32'h0);
    `CHK(q, 32'h0000_0180)
    wb(1'b0, 8'h40, 32'h0);
    `CHK(q, 32'h0)
    // override switches the discharge detectors off and back on
    ovr <= 1'b1;
    repeat (20) @(posedge clk_i);
    `CHK(ocd_en, 1'b0)
    ovr <= 1'b0;
    repeat (20) @(posedge clk_i);
    `CHK(ocd_en, 1'b1)
    // broken short pulses never reach the full delay
    repeat (3)
    begin
      short_circuit_fault <= 1'b1;
      repeat (100) @(posedge clk_i);
      short_circuit_fault <= 1'b0;
      repeat (100) @(posedge clk_i);
    end
    wb(1'b0, bfp_pkg::ADR_STAT, 32'h0);
    `CHK(q[9], 1'b0)
    // sustained short, load-only recovery
    short_circuit_fault <= 1'b1;
    wait_oe(1'b1);
    `CHK(ld_oe, 1'b1)
    `CHK(discharge_fet_drive, 1'b0)
    `CHK(ld_o, 1'b0)
    wb(1'b0, bfp_pkg::ADR_STAT, 32'h0);
    `CHK(q[9], 1'b1)
    short_circuit_fault <= 1'b0;
    repeat (2000) @(posedge clk_i);
    `CHK(ld_oe, 1'b1)
    load <= 1'b0;
    wait_oe(1'b0);
    wb(1'b0, bfp_pkg::ADR_STAT, 32'h0);
    `CHK(q[10:7], 4'h0)
    `CHK(charge_fet_drive, 1'b0)
    `CHK(bal, 5'h00)
    stop_test();
  end

  initial
  begin
    // tests need about 4000 cycles; allow a wide margin
    #100us;
    error_cnt++;
    stop_test();
  end
endmodule
